// ==== include/aqu_params.svh ====
// timing counts and field positions for the acquisition scan sequencer
// assumes the 10 MHz system clock; included by bare name
`ifndef AQU_PARAMS_SVH
`define AQU_PARAMS_SVH

`define AQU_CLK_PERIOD_NS 100
`define AQU_CHANNELS 16
`define AQU_CONV_BITS 12
`define AQU_BUS_BITS 16
`define AQU_SIGN_BIT 11
`define AQU_WR_PULSE_NS 200
`define AQU_SAMPLE_NS 10000
`define AQU_START_NS 3000
`define AQU_STAGE_NS 620
`define AQU_WR_PULSE_CYC ((`AQU_WR_PULSE_NS + `AQU_CLK_PERIOD_NS - 1) / `AQU_CLK_PERIOD_NS)
`define AQU_SAMPLE_CYC ((`AQU_SAMPLE_NS + `AQU_CLK_PERIOD_NS - 1) / `AQU_CLK_PERIOD_NS)
`define AQU_START_CYC ((`AQU_START_NS + `AQU_CLK_PERIOD_NS - 1) / `AQU_CLK_PERIOD_NS)
`define AQU_STAGE_CYC ((`AQU_STAGE_NS + `AQU_CLK_PERIOD_NS - 1) / `AQU_CLK_PERIOD_NS)
`define AQU_CHAIN_LEN 8
`define AQU_CNT_BITS 8

`endif

// ==== include/aqu_pkg.sv ====
// types shared by the acquisition scan sequencer modules
// assumes aqu_params.svh is on the include path
package aqu_pkg;
`include "aqu_params.svh"
    typedef logic [3:0] aqu_chan_type;
    typedef logic [`AQU_CONV_BITS-1:0] aqu_word_type;
    typedef logic [`AQU_BUS_BITS-1:0] aqu_bus_type;
    typedef logic [`AQU_CNT_BITS-1:0] aqu_cnt_type;
    typedef enum logic [1:0] {OS_IDLE, OS_WRITE, OS_SAMPLE, OS_START} aqu_os_state_type;
endpackage

// ==== include/aqu_ram_if.sv ====
// result memory port bundle between sequencer and memory
// assumes aqu_pkg compiled first
`timescale 1ns/10ps
interface aqu_ram_if;
    import aqu_pkg::*;
    logic we;
    aqu_chan_type waddr;
    aqu_word_type wdata;
    aqu_chan_type raddr;
    aqu_word_type rdata;
    modport seq (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== core/aqu_ram.sv ====
// 16-word result memory, stores converter bits inverted
// assumes single clock, write data stable during we
`timescale 1ns/10ps
`include "aqu_params.svh"
module aqu_ram
    import aqu_pkg::*;
(
    // clock
    input wire logic clock,
    // port bundle
    aqu_ram_if.mem ram
);
    aqu_word_type mem_r [`AQU_CHANNELS];

    genvar gi;
    generate
        for (gi = 0; gi < `AQU_CHANNELS; gi++) begin : g_word
            always_ff @(posedge clock) begin
                if (ram.we && ram.waddr == aqu_chan_type'(gi)) begin
                    mem_r[gi] <= ~ram.wdata;
                end
            end
        end
    endgenerate

    assign ram.rdata = mem_r[ram.raddr];
endmodule // aqu_ram

// ==== core/aqu_chain.sv ====
// shift-chain gate generator for the shift-register timing variant
// assumes done_s is already synchronised to clock
`timescale 1ns/10ps
`include "aqu_params.svh"
module aqu_chain
    import aqu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // control
    input wire logic done_s,
    input wire logic inhibit,
    // gates
    output logic wr_gate,
    output logic sample_gate,
    output logic start_gate,
    output logic wr_end,
    output logic conv_clk
);
    aqu_cnt_type tick_cnt_r;
    logic tick;
    logic conv_div_r;
    logic done_dly_r;
    logic [`AQU_CHAIN_LEN:1] gate_shift_chain_r;
    logic wr_gate_d_r;

    // double-rate tick, one stage per tick
    assign tick = (tick_cnt_r == aqu_cnt_type'(`AQU_STAGE_CYC - 1));

    always_ff @(posedge clock) begin
        if (srst || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            conv_div_r <= 1'b0;
        end else if (tick) begin
            conv_div_r <= ~conv_div_r;
        end
    end

    // delayed done, held off while the processor reads
    always_ff @(posedge clock) begin
        if (srst || !done_s) begin
            done_dly_r <= 1'b0;
        end else if (tick && !inhibit) begin
            done_dly_r <= 1'b1;
        end
    end

    // cleared in the same cycle as done_dly_r, so the write gate cannot pulse again
    always_ff @(posedge clock) begin
        if (srst || !done_s || !done_dly_r) begin
            gate_shift_chain_r <= '0;
        end else if (tick) begin
            gate_shift_chain_r <= {gate_shift_chain_r[`AQU_CHAIN_LEN-1:1], done_dly_r};
        end
    end

    assign wr_gate = done_dly_r ^ gate_shift_chain_r[1];
    assign sample_gate = gate_shift_chain_r[1] ^ gate_shift_chain_r[7];
    assign start_gate = gate_shift_chain_r[7] ^ gate_shift_chain_r[8];
    assign conv_clk = conv_div_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_gate_d_r <= 1'b0;
        end else begin
            wr_gate_d_r <= wr_gate;
        end
    end

    assign wr_end = wr_gate_d_r && !wr_gate;
endmodule // aqu_chain

// ==== core/aqu_sequencer.sv ====
// multiplexed acquisition unit scan sequencer with result memory
// assumes processor bus and converter pins are asynchronous to clock
`timescale 1ns/10ps
`include "aqu_params.svh"
module aqu_sequencer
    import aqu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // straps
    input wire logic strap_shift_timing,
    input wire logic strap_sign_fill,
    // converter and sample-hold
    input wire logic conversion_done_n,
    input wire logic [`AQU_CONV_BITS-1:0] conv_data_n,
    output logic begin_convert_n,
    output logic sample_hold,
    output logic conv_clk,
    output logic [3:0] mux_sel,
    // processor bus
    input wire logic addr_valid,
    input wire logic mem_read_n,
    input wire logic [3:0] bus_addr,
    output logic [`AQU_BUS_BITS-1:0] data_out,
    output logic data_oe,
    output logic ack_out,
    output logic ack_oe
);
    // synchronisers
    logic done_m_r, done_s_r;
    logic valid_m_r, valid_s_r;
    logic rd_m_r, rd_s_r;
    aqu_chan_type baddr_m_r, baddr_s_r;
    aqu_word_type cdata_m_r, cdata_s_r;
    logic shift_m_r, shift_s_r;
    logic fill_m_r, fill_s_r;

    // done turned active high on the way in
    always_ff @(posedge clock) begin
        done_m_r <= ~conversion_done_n;
        done_s_r <= done_m_r;
    end

    always_ff @(posedge clock) begin
        valid_m_r <= addr_valid;
        valid_s_r <= valid_m_r;
    end

    // read command turned active high on the way in
    always_ff @(posedge clock) begin
        rd_m_r <= ~mem_read_n;
        rd_s_r <= rd_m_r;
    end

    // address held steady by the processor while valid stands
    always_ff @(posedge clock) begin
        baddr_m_r <= bus_addr;
        baddr_s_r <= baddr_m_r;
    end

    // result held steady by the converter while done stands
    always_ff @(posedge clock) begin
        cdata_m_r <= conv_data_n;
        cdata_s_r <= cdata_m_r;
    end

    always_ff @(posedge clock) begin
        shift_m_r <= strap_shift_timing;
        shift_s_r <= shift_m_r;
    end

    always_ff @(posedge clock) begin
        fill_m_r <= strap_sign_fill;
        fill_s_r <= fill_m_r;
    end

    // straps caught while reset is held
    logic mode_shift_r;
    logic mode_fill_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            mode_shift_r <= shift_s_r;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mode_fill_r <= fill_s_r;
        end
    end

    // output format on read data
    function automatic aqu_bus_type fmt_word(input aqu_word_type w, input logic fill);
        aqu_bus_type r;
        r = {{(`AQU_BUS_BITS-`AQU_CONV_BITS){fill & w[`AQU_SIGN_BIT]}}, w};
        return r;
    endfunction

    // one-shot timing path
    aqu_os_state_type os_state_r, os_state_nxt;
    aqu_cnt_type os_cnt_r, os_cnt_nxt;
    logic done_d_r;
    logic done_pend_r;
    logic done_edge;
    logic os_wr_end;
    logic os_take;

    assign done_edge = done_s_r && !done_d_r;
    // an edge is taken at once only from idle with no read standing
    assign os_take = (os_state_r == OS_IDLE) && !valid_s_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            done_d_r <= 1'b0;
        end else begin
            done_d_r <= done_s_r;
        end
    end

    // remembers only an edge that could not be taken, else a stale write follows
    always_ff @(posedge clock) begin
        if (srst || mode_shift_r) begin
            done_pend_r <= 1'b0;
        end else if (done_edge && !os_take) begin
            done_pend_r <= 1'b1;
        end else if (os_take) begin
            done_pend_r <= 1'b0;
        end
    end

    always_comb begin
        os_state_nxt = os_state_r;
        os_cnt_nxt = os_cnt_r;
        os_wr_end = 1'b0;
        case (os_state_r)
            OS_IDLE: begin
                if ((done_pend_r || done_edge) && !valid_s_r) begin
                    os_state_nxt = OS_WRITE;
                    os_cnt_nxt = aqu_cnt_type'(`AQU_WR_PULSE_CYC - 1);
                end
            end
            OS_WRITE: begin
                if (os_cnt_r == '0) begin
                    os_wr_end = 1'b1;
                    os_state_nxt = OS_SAMPLE;
                    os_cnt_nxt = aqu_cnt_type'(`AQU_SAMPLE_CYC - 1);
                end else begin
                    os_cnt_nxt = os_cnt_r - 8'h01;
                end
            end
            OS_SAMPLE: begin
                if (os_cnt_r == '0) begin
                    os_state_nxt = OS_START;
                    os_cnt_nxt = aqu_cnt_type'(`AQU_START_CYC - 1);
                end else begin
                    os_cnt_nxt = os_cnt_r - 8'h01;
                end
            end
            OS_START: begin
                if (os_cnt_r == '0) begin
                    os_state_nxt = OS_IDLE;
                end else begin
                    os_cnt_nxt = os_cnt_r - 8'h01;
                end
            end
            default: begin
                os_state_nxt = OS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst || mode_shift_r) begin
            os_state_r <= OS_IDLE;
        end else begin
            os_state_r <= os_state_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || mode_shift_r) begin
            os_cnt_r <= '0;
        end else begin
            os_cnt_r <= os_cnt_nxt;
        end
    end

    // shift-register timing path
    logic ch_wr_gate, ch_sample_gate, ch_start_gate, ch_wr_end, ch_conv_clk;

    aqu_chain u_chain (
        .clock(clock),
        .srst(srst || !mode_shift_r),
        .done_s(done_s_r),
        .inhibit(valid_s_r),
        .wr_gate(ch_wr_gate),
        .sample_gate(ch_sample_gate),
        .start_gate(ch_start_gate),
        .wr_end(ch_wr_end),
        .conv_clk(ch_conv_clk)
    );

    // common view of the active timing path
    logic wr_active;
    logic sample_active;
    logic start_active;
    logic advance;

    assign wr_active = mode_shift_r ? ch_wr_gate : (os_state_r == OS_WRITE);
    assign sample_active = mode_shift_r ? ch_sample_gate : (os_state_r == OS_SAMPLE);
    assign start_active = mode_shift_r ? ch_start_gate : (os_state_r == OS_START);
    assign advance = mode_shift_r ? ch_wr_end : os_wr_end;

    // channel counter
    aqu_chan_type chan_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            chan_r <= '0;
        end else if (advance) begin
            chan_r <= chan_r + 4'h1;
        end
    end

    // processor grant, held off by a write in progress
    logic grant_r;

    always_ff @(posedge clock) begin
        if (srst || !valid_s_r) begin
            grant_r <= 1'b0;
        end else if (!wr_active) begin
            grant_r <= 1'b1;
        end
    end

    // result memory
    aqu_ram_if ram_bus ();

    assign ram_bus.we = wr_active;
    assign ram_bus.waddr = chan_r;
    assign ram_bus.wdata = cdata_s_r;
    assign ram_bus.raddr = grant_r ? baddr_s_r : chan_r;

    aqu_ram u_ram (
        .clock(clock),
        .ram(ram_bus.mem)
    );

    // bus answer
    logic read_on;

    assign read_on = grant_r && rd_s_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            data_out <= '0;
        end else begin
            data_out <= read_on ? fmt_word(ram_bus.rdata, mode_fill_r) : '0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            data_oe <= 1'b0;
        end else begin
            data_oe <= read_on;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ack_out <= 1'b0;
        end else begin
            ack_out <= read_on;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ack_oe <= 1'b0;
        end else begin
            ack_oe <= read_on;
        end
    end

    // converter and sample-hold pins
    always_ff @(posedge clock) begin
        if (srst) begin
            begin_convert_n <= 1'b1;
        end else begin
            begin_convert_n <= ~start_active;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sample_hold <= 1'b0;
        end else begin
            sample_hold <= sample_active;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            conv_clk <= 1'b0;
        end else begin
            conv_clk <= mode_shift_r ? ch_conv_clk : 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mux_sel <= '0;
        end else begin
            mux_sel <= chan_r;
        end
    end
endmodule // aqu_sequencer

// ==== test/aqu_sequencer_checker.sv ====
// pin-level assertions for the acquisition scan sequencer
// assumes straps steady after reset; bound onto aqu_sequencer
`timescale 1ns/10ps
module aqu_sequencer_checker
    import aqu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // converter side
    input wire logic strap_shift_timing,
    input wire logic begin_convert_n,
    input wire logic sample_hold,
    input wire logic conv_clk,
    input wire logic [3:0] mux_sel,
    // processor side
    input wire logic addr_valid,
    input wire logic mem_read_n,
    input wire aqu_bus_type data_out,
    input wire logic data_oe,
    input wire logic ack_out,
    input wire logic ack_oe
);
    aqu_cnt_type lo_r, hi_r, rd_r;

    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    always_ff @(posedge clock) begin
        lo_r <= begin_convert_n ? 8'h00 : lo_r + 8'h01;
    end
    always_ff @(posedge clock) begin
        hi_r <= sample_hold ? hi_r + 8'h01 : 8'h00;
    end
    // cycles of a standing read, saturating
    always_ff @(posedge clock) begin
        if (!addr_valid || mem_read_n) begin
            rd_r <= 8'h00;
        end else if (rd_r != 8'hFF) begin
            rd_r <= rd_r + 8'h01;
        end
    end

    sequence s_step;
        $changed(mux_sel);
    endsequence
    sequence s_sample_end;
        $fell(sample_hold);
    endsequence

    a_chan_wraps: assert property (s_step |-> mux_sel == $past(mux_sel) + 4'h1)
        else $error("channel did not step by one");
    a_step_samples: assert property (s_step |-> ##[0:1] sample_hold)
        else $error("no sample after channel step");
    a_sample_width: assert property (s_sample_end |-> hi_r == (strap_shift_timing ? 8'h2A : 8'h64))
        else $error("sample period width wrong");
    a_hold_starts: assert property (s_sample_end |-> ##[0:1] !begin_convert_n)
        else $error("no convert start after sample");
    a_start_width: assert property ($rose(begin_convert_n) |-> lo_r == (strap_shift_timing ? 8'h07 : 8'h1E))
        else $error("convert start width wrong");
    a_clk_divide: assert property ($changed(conv_clk) |=> $stable(conv_clk) [*6])
        else $error("converter clock period wrong");
    a_read_no_wait: assert property (rd_r == 8'h10 |-> ack_out && ack_oe && data_oe)
        else $error("read not answered in time");
    a_scan_held: assert property (rd_r >= 8'h14 |-> $stable(mux_sel))
        else $error("scan moved during read");
    a_ack_with_data: assert property (ack_out |-> ack_oe && data_oe)
        else $error("acknowledge without data drive");
    a_read_release: assert property ($rose(mem_read_n) |-> ##[1:4] !ack_oe && !data_oe)
        else $error("bus not released after read");
    a_data_quiet: assert property (!data_oe |-> data_out == 16'h0000)
        else $error("data not zero while idle");
endmodule // aqu_sequencer_checker

bind aqu_sequencer aqu_sequencer_checker i_chk (.clock(clock), .srst(srst), .strap_shift_timing(strap_shift_timing),
    .begin_convert_n(begin_convert_n), .sample_hold(sample_hold), .conv_clk(conv_clk), .mux_sel(mux_sel),
    .addr_valid(addr_valid), .mem_read_n(mem_read_n), .data_out(data_out), .data_oe(data_oe),
    .ack_out(ack_out), .ack_oe(ack_oe));

// ==== test/aqu_conv_model.sv ====
// converter with sample-hold facing the scan sequencer
// assumes conversion runs after the start pulse ends; done stays low until then
`timescale 1ns/10ps
`include "aqu_params.svh"
module aqu_conv_model (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // control
    input wire logic slow,
    input wire logic begin_convert_n,
    input wire logic sample_hold,
    input wire logic [3:0] mux_sel,
    // result
    output logic conversion_done_n,
    output logic [`AQU_CONV_BITS-1:0] conv_data_n
);
    logic [3:0] held_r;
    int busy_r;

    // tracks while sampling, keeps channel in hold
    always_ff @(posedge clock) begin
        if (srst) begin
            held_r <= 4'h0;
        end else if (sample_hold) begin
            held_r <= mux_sel;
        end
    end
    // data lines toggle while no result is valid
    always_ff @(posedge clock) begin
        if (srst) begin
            busy_r <= slow ? 250 : 20;
            conversion_done_n <= 1'h1;
            conv_data_n <= 12'hA5A;
        end else if (!begin_convert_n) begin
            busy_r <= slow ? 250 : 20;
        end else if (busy_r > 1) begin
            busy_r <= busy_r - 1;
            conversion_done_n <= 1'h1;
            conv_data_n <= ~conv_data_n;
        end else if (busy_r == 1) begin
            busy_r <= 0;
            conversion_done_n <= 1'h0;
            conv_data_n <= ~{held_r, ~held_r, held_r};
        end
    end
endmodule // aqu_conv_model

// ==== test/tb_top.sv ====
// self-checking bench for the acquisition scan sequencer
// assumes the converter model answers on the far side
`timescale 1ns/10ps
`include "aqu_params.svh"
module tb_top;
    logic clock, srst, strap_shift_timing, strap_sign_fill, slow, addr_valid, mem_read_n;
    logic conversion_done_n, begin_convert_n, sample_hold, conv_clk, data_oe, ack_out, ack_oe;
    logic [`AQU_CONV_BITS-1:0] conv_data_n;
    logic [`AQU_BUS_BITS-1:0] data_out;
    logic [3:0] mux_sel, bus_addr;
    int errors, comparisons;

    aqu_sequencer i_dut (.clock(clock), .srst(srst), .strap_shift_timing(strap_shift_timing),
        .strap_sign_fill(strap_sign_fill), .conversion_done_n(conversion_done_n), .conv_data_n(conv_data_n),
        .begin_convert_n(begin_convert_n), .sample_hold(sample_hold), .conv_clk(conv_clk), .mux_sel(mux_sel),
        .addr_valid(addr_valid), .mem_read_n(mem_read_n), .bus_addr(bus_addr), .data_out(data_out),
        .data_oe(data_oe), .ack_out(ack_out), .ack_oe(ack_oe));
    aqu_conv_model i_conv (.clock(clock), .srst(srst), .slow(slow), .begin_convert_n(begin_convert_n),
        .sample_hold(sample_hold), .mux_sel(mux_sel), .conversion_done_n(conversion_done_n),
        .conv_data_n(conv_data_n));

    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end

    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [15:0] exp_word(input logic [3:0] ch);
        logic [11:0] v;
        v = {ch, ~ch, ch};
        return {strap_sign_fill ? {4{v[11]}} : 4'h0, v};
    endfunction

    task automatic scan_check();
        logic [3:0] prev;
        int t;
        prev = mux_sel;
        for (int n = 0; n < 17; n++) begin
            t = 0;
            while (mux_sel === prev && t < 700) begin
                @(negedge clock);
                t++;
            end
            check("scan channel", {12'h000, prev + 4'h1}, {12'h000, mux_sel});
            prev = mux_sel;
        end
    endtask

    task automatic read_chan(input logic [3:0] ch);
        int t;
        @(negedge clock);
        addr_valid = 1'h1;
        mem_read_n = 1'h0;
        bus_addr = ch;
        t = 0;
        @(negedge clock);
        while (ack_out !== 1'h1 && t < 40) begin
            @(negedge clock);
            t++;
        end
        check("read ack", 16'h0001, {15'h0000, ack_out});
        check("read data", exp_word(ch), data_out);
        @(negedge clock);
        addr_valid = 1'h0;
        mem_read_n = 1'h1;
        repeat (4) @(negedge clock);
        check("bus released", 16'h0000, {14'h0000, ack_oe, data_oe});
    endtask

    // long read: scan must freeze, then pick up where it stopped
    task automatic hold_scan();
        logic [3:0] ch;
        int t;
        @(negedge clock);
        addr_valid = 1'h1;
        mem_read_n = 1'h0;
        bus_addr = 4'h3;
        repeat (20) @(negedge clock);
        ch = mux_sel;
        repeat (600) @(negedge clock);
        check("held channel", {12'h000, ch}, {12'h000, mux_sel});
        check("held data", exp_word(4'h3), data_out);
        addr_valid = 1'h0;
        mem_read_n = 1'h1;
        t = 0;
        while (mux_sel === ch && t < 700) begin
            @(negedge clock);
            t++;
        end
        check("resumed channel", {12'h000, ch + 4'h1}, {12'h000, mux_sel});
    endtask

    task automatic run(input logic shift, input logic fill, input logic slw);
        @(negedge clock);
        srst = 1'h1;
        strap_shift_timing = shift;
        strap_sign_fill = fill;
        slow = slw;
        repeat (6) @(negedge clock);
        srst = 1'h0;
        scan_check();
        for (int c = 15; c >= 0; c--) begin
            read_chan(c[3:0]);
        end
        hold_scan();
    endtask

    initial begin
        errors = 0;
        comparisons = 0;
        srst = 1'h1;
        strap_shift_timing = 1'h0;
        strap_sign_fill = 1'h0;
        slow = 1'h0;
        addr_valid = 1'h0;
        mem_read_n = 1'h1;
        bus_addr = 4'h0;
        run(1'h0, 1'h0, 1'h0);
        run(1'h1, 1'h1, 1'h1);
        print_verdict();
    end

    initial begin
        #3000000;
        errors++;
        print_verdict();
    end
endmodule // tb_top
